/* common/lmr_pkg.sv */
// Package: opcodes, field positions and reset values for the literal/move/return decoder
package lmr_pkg;
	localparam int unsigned INSN_W = 14;
	localparam int unsigned PC_W = 13;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned FADDR_W = 7;
	localparam logic [1:0] LIT_TOP = 2'h3;
	localparam logic [1:0] LIT_SUB = 2'h0;
	localparam logic [INSN_W-1:0] RETI_CODE = 14'h0009;
	localparam logic [INSN_W-1:0] CFGLOAD_CODE = 14'h0062;
	localparam logic [INSN_W-1:0] IDLE_MASK = 14'h3F9F;
	localparam logic [INSN_W-1:0] IDLE_CODE = 14'h0000;
	localparam logic [6:0] STORE_TOP = 7'h01;
	localparam int unsigned GIE_BIT = 7;
	localparam logic [FADDR_W-1:0] INTCTL_ADDR = 7'h0B;
	localparam logic [FADDR_W-1:0] CFG_ADDR = 7'h01;
	localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
	localparam logic [DATA_W-1:0] CFG_RST = 8'hFF;
	localparam logic [DATA_W-1:0] INTCTL_RST = 8'h00;
	localparam logic [PC_W-1:0] PC_RST = 13'h0000;
	localparam logic [DATA_W-1:0] STAT_RST = 8'h00;
	localparam logic [FADDR_W-1:0] WADDR_RST = 7'h00;
	localparam logic [DATA_W-1:0] WDATA_RST = 8'h00;
	localparam int unsigned RETI_CYCLES = 2;
	typedef enum logic [2:0] {
		LMR_OP_IDLE, LMR_OP_LIT, LMR_OP_STORE, LMR_OP_RETI, LMR_OP_CFG, LMR_OP_OTHER
	} lmr_op_e;
endpackage : lmr_pkg

/* common/lmr_dec_if.sv */
// Interface: decoded instruction fields passed from the decoder to the execute logic
`timescale 1ns/100ps
`default_nettype none
interface lmr_dec_if;
	import lmr_pkg::*;
	lmr_op_e op;
	logic [DATA_W-1:0] lit;
	logic [FADDR_W-1:0] faddr;
	modport dec (output op, output lit, output faddr);
	modport exe (input op, input lit, input faddr);
endinterface : lmr_dec_if
`default_nettype wire

/* rtl/lmr_decode.sv */
// Pure combinational decoder of the instruction word
`timescale 1ns/100ps
`default_nettype none
module lmr_decode (
	input wire logic [lmr_pkg::INSN_W-1:0] insn,
	lmr_dec_if.dec dec
);
	import lmr_pkg::*;
	always_comb begin
		dec.lit = insn[DATA_W-1:0];
		dec.faddr = insn[FADDR_W-1:0];
		// Bits 9:8 of the literal load are ignored whatever they hold
		if (insn[13:12] == LIT_TOP && insn[11:10] == LIT_SUB) begin
			dec.op = LMR_OP_LIT; // RL1 RL2
		end else if (insn[13:7] == STORE_TOP) begin
			dec.op = LMR_OP_STORE; // RL3
		end else if (insn == RETI_CODE) begin
			dec.op = LMR_OP_RETI; // RL4
		end else if (insn == CFGLOAD_CODE) begin
			dec.op = LMR_OP_CFG; // RL7
		end else if ((insn & IDLE_MASK) == IDLE_CODE) begin
			dec.op = LMR_OP_IDLE; // RL9
		end else begin
			dec.op = LMR_OP_OTHER;
		end
	end
endmodule : lmr_decode
`default_nettype wire

/* rtl/lmr_core.sv */
// Execute logic for literal load, accumulator store, idle, return from interrupt, config load
//
// Function
// [RL1] A literal load puts the low 8 bits of the word into the accumulator in one cycle, no flags.
// [RL2] The two don't-care bits of the literal load are zero from tools and ignored by the decoder.
// [RL3] A store copies the accumulator into the file register at the 7-bit address, one cycle.
// [RL4] Return from interrupt pops the stack and loads the popped top into the program counter.
// [RL5] Return from interrupt also sets the global enable, bit 7 of the interrupt control reg.
// [RL6] Return from interrupt takes two instruction cycles and alters no status flags.
// [RL7] The config-load word copies the accumulator into the timer/prescaler config register.
// [RL8] The config register is also readable and writable at its ordinary file address.
// [RL9] The idle word completes in one cycle and only advances the program counter.
`timescale 1ns/100ps
`default_nettype none
module lmr_core (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic [lmr_pkg::INSN_W-1:0] insn,
	input wire logic [lmr_pkg::PC_W-1:0] stack_top,
	input wire logic [lmr_pkg::DATA_W-1:0] file_rdata,
	input wire logic [lmr_pkg::DATA_W-1:0] status_in,
	output logic [lmr_pkg::PC_W-1:0] pc,
	output logic [lmr_pkg::DATA_W-1:0] acc,
	output logic [lmr_pkg::DATA_W-1:0] cfg_reg,
	output logic [lmr_pkg::DATA_W-1:0] intctl_reg,
	output logic [lmr_pkg::DATA_W-1:0] status_out,
	output logic file_we,
	output logic [lmr_pkg::FADDR_W-1:0] file_addr,
	output logic [lmr_pkg::DATA_W-1:0] file_wdata,
	output logic stack_pop,
	output logic fetch_stall
);
	import lmr_pkg::*;

	lmr_dec_if dif ();

	lmr_decode u_dec (
		.insn(insn),
		.dec(dif)
	);

	// Execute-stage state; the write and pop outputs are pulses of one enabled cycle, held while the enable is low
	logic [PC_W-1:0] pc_q, pc_d;
	logic [DATA_W-1:0] acc_q, acc_d;
	logic [DATA_W-1:0] cfg_q, cfg_d;
	logic [DATA_W-1:0] ictl_q, ictl_d;
	logic [DATA_W-1:0] stat_q, stat_d;
	logic we_q, we_d;
	logic [FADDR_W-1:0] waddr_q, waddr_d;
	logic [DATA_W-1:0] wdata_q, wdata_d;
	logic pop_q, pop_d;
	logic reti2_q, reti2_d;

	// Second cycle of a return is a forced bubble: the fetched word is ignored.
	always_comb begin
		pc_d = pc_q;
		acc_d = acc_q;
		cfg_d = cfg_q;
		ictl_d = ictl_q;
		stat_d = status_in; // RL6
		we_d = 1'b0;
		waddr_d = waddr_q;
		wdata_d = wdata_q;
		pop_d = 1'b0;
		reti2_d = 1'b0;
		if (reti2_q) begin
			reti2_d = 1'b0;
		end else begin
			pc_d = pc_q + 13'h0001;
			unique case (dif.op)
				LMR_OP_LIT: begin
					acc_d = dif.lit; // RL1 RL2
				end
				LMR_OP_STORE: begin
					we_d = 1'b1; // RL3
					waddr_d = dif.faddr;
					wdata_d = acc_q;
					// Direct access to the config and interrupt-control copies
					if (dif.faddr == CFG_ADDR) begin
						cfg_d = acc_q; // RL8
					end
					if (dif.faddr == INTCTL_ADDR) begin
						ictl_d = acc_q;
					end
				end
				LMR_OP_RETI: begin
					pc_d = stack_top; // RL4
					pop_d = 1'b1; // RL4
					ictl_d[GIE_BIT] = 1'b1; // RL5
					reti2_d = 1'b1; // RL6
				end
				LMR_OP_CFG: begin
					cfg_d = acc_q; // RL7
				end
				LMR_OP_IDLE: begin
				end // RL9
				LMR_OP_OTHER: begin
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pc_q <= PC_RST;
			acc_q <= ACC_RST;
			cfg_q <= CFG_RST;
			ictl_q <= INTCTL_RST;
			stat_q <= STAT_RST;
			we_q <= 1'b0;
			waddr_q <= WADDR_RST;
			wdata_q <= WDATA_RST;
			pop_q <= 1'b0;
			reti2_q <= 1'b0;
		end else if (clk_en) begin
			pc_q <= pc_d;
			acc_q <= acc_d;
			cfg_q <= cfg_d;
			ictl_q <= ictl_d;
			stat_q <= stat_d;
			we_q <= we_d;
			waddr_q <= waddr_d;
			wdata_q <= wdata_d;
			pop_q <= pop_d;
			reti2_q <= reti2_d;
		end
	end

	// No read instruction lives in this block; the read data stays on the port for the wider
	// core and is folded into an unread net so that nothing is left dangling.
	logic unused_rd;
	assign unused_rd = ^file_rdata;

	// Ports are plain copies of the registers, so no output has a logic path behind it
	assign pc = pc_q;
	assign acc = acc_q;
	assign cfg_reg = cfg_q;
	assign intctl_reg = ictl_q;
	assign status_out = stat_q;
	assign file_we = we_q;
	assign file_addr = waddr_q;
	assign file_wdata = wdata_q;
	assign stack_pop = pop_q;
	assign fetch_stall = reti2_q;

	// Reset disables every check, so no $past value reaches back into a reset cycle
	sequence s_reti_start;
		clk_en && !reti2_q && dif.op == LMR_OP_RETI;
	endsequence
	// Second step of a return: the bubble edge, counted only when it is enabled
	sequence s_reti_bubble;
		fetch_stall && clk_en;
	endsequence
	AST_LIT_LOAD: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL1
		clk_en && !reti2_q && dif.op == LMR_OP_LIT |=> acc_q == $past(insn[7:0]))
		else $error("literal not loaded");
	AST_LIT_DONTCARE: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL2
		insn[13:10] == 4'hC |-> dif.op == LMR_OP_LIT)
		else $error("don't-care bits changed decode");
	AST_ACC_HOLD: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL3 RL7 RL9
		clk_en && (reti2_q || dif.op != LMR_OP_LIT) |=> $stable(acc_q))
		else $error("accumulator changed without a literal load");
	AST_FLAGS_KEPT: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL1 RL3 RL6 RL7
		clk_en |=> status_out == $past(status_in))
		else $error("status flags altered");
	AST_STORE: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL3
		clk_en && !reti2_q && dif.op == LMR_OP_STORE |=>
		file_we && file_wdata == $past(acc_q) && file_addr == $past(insn[6:0]))
		else $error("store missing");
	AST_STORE_ONLY: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL3
		clk_en && (reti2_q || dif.op != LMR_OP_STORE) |=> !file_we)
		else $error("file write without a store");
	AST_RETI_POP: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL4
		s_reti_start |=> stack_pop && pc_q == $past(stack_top))
		else $error("return did not pop");
	AST_POP_ONLY: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL4
		clk_en && (reti2_q || dif.op != LMR_OP_RETI) |=> !stack_pop)
		else $error("stack popped without a return");
	AST_RETI_GIE: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL5
		s_reti_start |=> intctl_reg[GIE_BIT])
		else $error("global enable not set");
	AST_RETI_ICTL_REST: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL5
		s_reti_start |=> intctl_reg[6:0] == $past(ictl_q[6:0]))
		else $error("return disturbed other interrupt control bits");
	AST_ICTL_HOLD: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL5
		clk_en && (reti2_q || (dif.op != LMR_OP_RETI
		&& !(dif.op == LMR_OP_STORE && insn[6:0] == INTCTL_ADDR))) |=> $stable(ictl_q))
		else $error("interrupt control changed unasked");
	AST_ICTL_DIRECT: assert property (@(posedge sys_clk) disable iff (!arst_n)
		clk_en && !reti2_q && dif.op == LMR_OP_STORE && insn[6:0] == INTCTL_ADDR
		|=> ictl_q == $past(acc_q))
		else $error("direct interrupt control write lost");
	AST_RETI_STALL: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL6
		s_reti_start |=> fetch_stall)
		else $error("return bubble missing");
	AST_RETI_TWO: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL6
		s_reti_start ##1 s_reti_bubble |=> !fetch_stall && $stable(pc_q)
		&& $stable(acc_q) && $stable(cfg_q) && !file_we && !stack_pop)
		else $error("return not two cycles");
	AST_CFG_LOAD: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL7
		clk_en && !reti2_q && dif.op == LMR_OP_CFG |=> cfg_q == $past(acc_q))
		else $error("config not loaded");
	AST_CFG_DIRECT: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL8
		clk_en && !reti2_q && dif.op == LMR_OP_STORE && insn[6:0] == CFG_ADDR
		|=> cfg_q == $past(acc_q))
		else $error("direct config write lost");
	AST_CFG_HOLD: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL7 RL8
		clk_en && (reti2_q || (dif.op != LMR_OP_CFG
		&& !(dif.op == LMR_OP_STORE && insn[6:0] == CFG_ADDR))) |=> $stable(cfg_q))
		else $error("config changed unasked");
	AST_PC_STEP: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL9
		clk_en && !reti2_q && dif.op != LMR_OP_RETI |=> pc_q == $past(pc_q) + 13'h0001)
		else $error("program counter did not advance by one");
	AST_IDLE: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL9
		clk_en && !reti2_q && dif.op == LMR_OP_IDLE |=> $stable(acc_q) && $stable(cfg_q)
		&& $stable(ictl_q) && !file_we && !stack_pop)
		else $error("idle changed state");
	// A low enable must freeze the pc, accumulator, config and interrupt-control registers, pulses included
	AST_FREEZE: assert property (@(posedge sys_clk) disable iff (!arst_n)
		!clk_en |=> $stable(pc_q) && $stable(acc_q) && $stable(cfg_q) && $stable(ictl_q)
		&& $stable(file_we) && $stable(stack_pop) && $stable(fetch_stall))
		else $error("state moved while disabled");
endmodule : lmr_core
`default_nettype wire

/* bench/literal_move_return_decode_test.sv */
// Testbench: random instruction stream checked against a reference model
`timescale 1ns/100ps
`default_nettype none
module literal_move_return_decode_test;
	import lmr_pkg::*;
	logic sys_clk, arst_n, clk_en, file_we, stack_pop, fetch_stall;
	logic [INSN_W-1:0] insn;
	logic [PC_W-1:0] stack_top, pc, m_pc;
	logic [DATA_W-1:0] file_rdata, status_in, acc, cfg_reg, intctl_reg, status_out, file_wdata;
	logic [DATA_W-1:0] m_acc, m_cfg, m_ic, m_st, m_wd;
	logic [FADDR_W-1:0] file_addr, m_ad;
	logic m_we, m_pop, m_stall, en_q;
	logic [31:0] rnd;
	int mismatches, n_tests;
	lmr_core dut (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en), .insn(insn),
		.stack_top(stack_top), .file_rdata(file_rdata), .status_in(status_in), .pc(pc),
		.acc(acc), .cfg_reg(cfg_reg), .intctl_reg(intctl_reg), .status_out(status_out),
		.file_we(file_we), .file_addr(file_addr), .file_wdata(file_wdata),
		.stack_pop(stack_pop), .fetch_stall(fetch_stall));
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : close_out
	// Stores favour the two mirrored addresses so their side effects are exercised often
	function automatic logic [INSN_W-1:0] pick(input logic [31:0] r);
		logic [FADDR_W-1:0] a;
		a = r[20] ? (r[21] ? CFG_ADDR : INTCTL_ADDR) : r[6:0];
		case (r[18:16])
			3'h0, 3'h1: return {LIT_TOP, LIT_SUB, r[9:8], r[7:0]};
			3'h2: return {STORE_TOP, a};
			3'h3: return RETI_CODE;
			3'h4: return CFGLOAD_CODE;
			3'h5: return IDLE_CODE | {7'h00, r[6:5], 5'h00};
			default: return r[13:0];
		endcase
	endfunction : pick
	task automatic model();
		en_q = clk_en;
		if (!clk_en) return;
		m_st = status_in;
		m_we = 1'b0;
		m_pop = 1'b0;
		if (m_stall) begin
			m_stall = 1'b0;
			return;
		end
		m_pc = m_pc + 13'h0001;
		if (insn[13:12] == LIT_TOP && insn[11:10] == LIT_SUB) begin
			m_acc = insn[7:0];
		end else if (insn == RETI_CODE) begin
			m_pc = stack_top;
			m_pop = 1'b1;
			m_stall = 1'b1;
			m_ic[GIE_BIT] = 1'b1;
		end else if (insn == CFGLOAD_CODE) begin
			m_cfg = m_acc;
		end else if (insn[13:7] == STORE_TOP) begin
			m_we = 1'b1;
			m_ad = insn[6:0];
			m_wd = m_acc;
			if (m_ad == CFG_ADDR) m_cfg = m_acc;
			if (m_ad == INTCTL_ADDR) m_ic = m_acc;
		end
	endtask : model
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	initial begin
		mismatches = 0;
		n_tests = 0;
		rnd = 32'h3324;
		arst_n = 1'b0;
		clk_en = 1'b1;
		insn = IDLE_CODE;
		stack_top = 13'h0000;
		file_rdata = 8'h00;
		status_in = 8'h00;
		{m_pc, m_acc, m_cfg, m_ic, m_st} = {PC_RST, ACC_RST, CFG_RST, INTCTL_RST, 8'h00};
		{m_we, m_pop, m_stall, en_q} = 4'h1;
		repeat (4) @(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (3000) begin
			#1;
			chk("pc", pc, m_pc);
			chk("acc", acc, m_acc);
			chk("cfg_reg", cfg_reg, m_cfg);
			chk("intctl_reg", intctl_reg, m_ic);
			chk("status_out", status_out, m_st);
			if (en_q) begin
				chk("file_we", file_we, m_we);
				chk("stack_pop", stack_pop, m_pop);
				chk("fetch_stall", fetch_stall, m_stall);
				if (m_we) chk("file_wr", {file_addr, file_wdata}, {m_ad, m_wd});
			end
			@(posedge sys_clk);
			model();
			rnd = lfsr(rnd);
			insn <= pick(rnd);
			stack_top <= rnd[28:16];
			status_in <= rnd[31:24];
			file_rdata <= rnd[15:8];
			clk_en <= (rnd[27:25] != 3'h0);
		end
		close_out();
	end
endmodule : literal_move_return_decode_test
`default_nettype wire
